/* include/dac_pkg.sv */
// Shared constants for the converter enable and digital volume block.
package dac_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] VOL_L_IDX = 8'h0A;
  localparam logic [7:0] VOL_R_IDX = 8'h0B;
  localparam logic [7:0] PWR_IDX   = 8'h1A;
  localparam logic [7:0] CLK_IDX   = 8'h1C;
  localparam logic [7:0] STAT_IDX  = 8'h1D;
  // Field positions.
  localparam int LEFT_EN_BIT  = 8;
  localparam int RIGHT_EN_BIT = 7;
  localparam int COMMIT_BIT   = 8;
  localparam int GATE_BIT     = 0;
  localparam int RATIO_LSB    = 1;
  localparam int RATE_LSB     = 4;
  localparam int STAT_GATE    = 16;
  // Values after reset.
  localparam logic [7:0] VOL_RESET   = 8'hC0;
  localparam logic [2:0] RATIO_RESET = 3'h2;
  localparam logic [1:0] RATE_RESET  = 2'h0;
  localparam logic       EN_RESET    = 1'b0;
  localparam logic       GATE_RESET  = 1'b0;
  // Data widths.
  localparam int SAMPLE_W = 24;
  localparam int CODE_W   = 8;
  // Core clock cycles per converter tick for each master clock ratio code.
  localparam logic [4:0] RATIO_DIV [8] = '{5'h02, 5'h03, 5'h04, 5'h06,
                                           5'h08, 5'h0C, 5'h10, 5'h18};
  // Gain code offset that places code 192 on a shift boundary.
  localparam logic [8:0] CODE_BIAS = 9'h040;
  // Fraction bits of mantissa and exponent bias of the gain product.
  localparam logic [5:0] GAIN_FRAC = 6'h1F;
  // Sixteen 0.375 dB steps within one 6 dB octave, unity at 8000h.
  localparam logic [15:0] MANT [16] = '{
    16'h8000, 16'h85A6, 16'h8B8B, 16'h91B3, 16'h9821, 16'h9ED7, 16'hA5D9, 16'hAD2A,
    16'hB4CE, 16'hBCC8, 16'hC51C, 16'hCDCE, 16'hD6E3, 16'hE05D, 16'hEA43, 16'hF499};
endpackage

/* logic/channel_path.sv */
// One converter channel: interpolating smoother followed by the digital gain stage.
`timescale 1ns/1ps
module channel_path
  import dac_pkg::*;
(
  input  wire logic                          pclk,      // Core clock.
  input  wire logic                          presetn,   // Asynchronous reset, active low.
  input  wire logic                          enable,    // Channel enable.
  input  wire logic                          tick,      // Converter rate tick.
  input  wire logic [dac_pkg::SAMPLE_W-1:0]  word,      // Current sample word.
  input  wire logic [dac_pkg::CODE_W-1:0]    gain_code, // Active volume code.
  output logic      [dac_pkg::SAMPLE_W-1:0]  level_out  // Scaled output level.
);
  import dac_pkg::*;

  typedef struct packed {
    logic [SAMPLE_W-1:0] acc;
    logic [SAMPLE_W-1:0] out;
  } path_t;

  path_t              st;
  path_t              next_st;
  logic signed [24:0] diff;
  logic signed [24:0] step;
  logic        [8:0]  k;
  logic signed [41:0] prod;
  logic signed [41:0] scaled;
  logic        [5:0]  shamt;

  // Smooth toward the new word at full width, then scale by mantissa and shift.
  always_comb begin
    next_st = st;
    diff    = $signed({word[SAMPLE_W-1], word}) - $signed({st.acc[SAMPLE_W-1], st.acc});
    step    = diff >>> 2;
    k       = {1'b0, gain_code} + CODE_BIAS;
    prod    = $signed(st.acc) * $signed({2'b00, MANT[k[3:0]]});
    shamt   = GAIN_FRAC - {1'b0, k[8:4]};
    scaled  = prod >>> shamt;
    if (!enable) begin
      next_st = '0;
    end else if (tick) begin
      next_st.acc = st.acc + step[SAMPLE_W-1:0];
      if (gain_code == '0) begin
        next_st.out = '0;
      end else if (!scaled[41] && (|scaled[40:23])) begin
        next_st.out = 24'h7FFFFF;
      end else if (scaled[41] && !(&scaled[40:23])) begin
        next_st.out = 24'h800000;
      end else begin
        next_st.out = scaled[SAMPLE_W-1:0];
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.out;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_off_is_silent: assert property (!enable |=> level_out == '0)
    else $error("disabled channel produced output");
  a_mute_code_zero: assert property (enable && tick && gain_code == '0 |=> level_out == '0)
    else $error("code zero did not mute");
  a_hold_between: assert property (enable && !tick |=> $stable(level_out))
    else $error("output moved without a tick");
  a_unity_pass: assert property (enable && tick && gain_code == VOL_RESET
                                 |=> level_out == $past(st.acc))
    else $error("unity code changed the level");
endmodule

/* logic/dac_volume_top.sv */
// Converter enables, rate tick and double-buffered digital volume behind APB.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module dac_volume_top
  import dac_pkg::*;
(
  input  wire logic                          pclk,       // Core clock, 125 MHz.
  input  wire logic                          presetn,    // Asynchronous reset, active low.
  input  wire logic                          psel,       // APB select.
  input  wire logic                          penable,    // APB access phase.
  input  wire logic                          pwrite,     // APB direction, high writes.
  input  wire logic [11:0]                   paddr,      // APB byte address.
  input  wire logic [31:0]                   pwdata,     // APB write data.
  output logic      [31:0]                   prdata,     // APB read data.
  output logic                               pready,     // APB ready.
  output logic                               pslverr,    // APB error on unmapped address.
  input  wire logic                          in_valid,   // Sample pair strobe.
  input  wire logic [dac_pkg::SAMPLE_W-1:0]  in_left,    // Left sample word.
  input  wire logic [dac_pkg::SAMPLE_W-1:0]  in_right,   // Right sample word.
  input  wire logic                          beep_on,    // Beep source selected.
  input  wire logic [dac_pkg::SAMPLE_W-1:0]  beep_word,  // Beep sample word.
  output logic                               conv_tick,  // Converter rate pulse.
  output logic      [dac_pkg::SAMPLE_W-1:0]  left_out,   // Left scaled level.
  output logic      [dac_pkg::SAMPLE_W-1:0]  right_out   // Right scaled level.
);
  import dac_pkg::*;

  typedef struct packed {
    logic [1:0]                enable;
    logic                      gate;
    logic [2:0]                ratio_sel;
    logic [1:0]                rate_sel;
    logic [1:0][CODE_W-1:0]    pend;
    logic [1:0][CODE_W-1:0]    act;
    logic [1:0][SAMPLE_W-1:0]  word;
    logic [4:0]                div_cnt;
    logic                      tick;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } ctrl_t;

  ctrl_t                     st;
  ctrl_t                     next_st;
  logic  [7:0]               idx;
  logic                      aligned;
  logic                      hit_l;
  logic                      hit_r;
  logic                      hit_pwr;
  logic                      hit_clk;
  logic                      hit_stat;
  logic                      mapped;
  logic                      setup;
  logic                      wr;
  logic                      commit;
  logic  [4:0]               div;
  logic  [1:0][SAMPLE_W-1:0] src;
  logic  [31:0]              rd;
  logic  [1:0][SAMPLE_W-1:0] next_word;

  // Address decode: one aligned word per register index.
  assign idx      = paddr[9:2];
  assign aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign hit_l    = aligned && (idx == VOL_L_IDX);
  assign hit_r    = aligned && (idx == VOL_R_IDX);
  assign hit_pwr  = aligned && (idx == PWR_IDX);
  assign hit_clk  = aligned && (idx == CLK_IDX);
  assign hit_stat = aligned && (idx == STAT_IDX);
  assign mapped   = hit_l || hit_r || hit_pwr || hit_clk || hit_stat;
  assign setup    = psel && !penable;
  assign wr       = psel && penable && st.pready && pwrite && mapped;
  assign commit   = wr && (hit_l || hit_r) && pwdata[COMMIT_BIT];

  // Divider chosen from ratio and frame rate settings, never below one cycle.
  always_comb begin
    div = RATIO_DIV[st.ratio_sel] >> st.rate_sel;
    if (div == 5'h00) begin
      div = 5'h01;
    end
  end

  // Sample sources: beep words replace interface words while selected.
  assign src[0] = beep_on ? beep_word : in_left;
  assign src[1] = beep_on ? beep_word : in_right;

  // Read multiplexer; the commit position always reads zero.
  always_comb begin
    rd = '0;
    if (hit_l) begin
      rd[CODE_W-1:0] = st.pend[0];
    end else if (hit_r) begin
      rd[CODE_W-1:0] = st.pend[1];
    end else if (hit_pwr) begin
      rd[LEFT_EN_BIT]  = st.enable[0];
      rd[RIGHT_EN_BIT] = st.enable[1];
    end else if (hit_clk) begin
      rd[GATE_BIT]               = st.gate;
      rd[RATIO_LSB +: 3]         = st.ratio_sel;
      rd[RATE_LSB +: 2]          = st.rate_sel;
    end else if (hit_stat) begin
      rd[CODE_W-1:0]             = st.act[0];
      rd[2*CODE_W-1:CODE_W]      = st.act[1];
      rd[STAT_GATE]              = st.gate;
    end
  end

  // Next state of the bus slave, register file, tick divider and sample words.
  always_comb begin
    next_st = st;
    // Each transfer has no wait state; pready and read data are registered in the setup cycle so read data comes from a flip-flop.
    if (setup) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !mapped;
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd;
    end else begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
    end
    if (wr && hit_pwr) begin
      next_st.enable[0] = pwdata[LEFT_EN_BIT];
      next_st.enable[1] = pwdata[RIGHT_EN_BIT];
    end
    if (wr && hit_clk) begin
      next_st.gate      = pwdata[GATE_BIT];
      next_st.ratio_sel = pwdata[RATIO_LSB +: 3];
      next_st.rate_sel  = pwdata[RATE_LSB +: 2];
    end
    // Pending codes load on any write; the commit strobe is not stored.
    if (wr && hit_l) begin
      next_st.pend[0] = pwdata[CODE_W-1:0];
    end
    if (wr && hit_r) begin
      next_st.pend[1] = pwdata[CODE_W-1:0];
    end
    // Both active gains take the pending codes in the same edge.
    if (commit) begin
      next_st.act = next_st.pend;
    end
    // Sample words come from the per-channel capture logic below.
    next_st.word = next_word;
    // Converter tick runs off the core clock only while the gate is set.
    if (st.gate) begin
      if (st.div_cnt >= div - 5'h01) begin
        next_st.div_cnt = 5'h00;
        next_st.tick    = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + 5'h01;
        next_st.tick    = 1'b0;
      end
    end else begin
      next_st.div_cnt = 5'h00;
      next_st.tick    = 1'b0;
    end
  end

  // Sample words are taken only into enabled channels.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_word
      always_comb begin
        if (!st.enable[i]) begin
          next_word[i] = '0;
        end else if (beep_on || in_valid) begin
          next_word[i] = src[i];
        end else begin
          next_word[i] = st.word[i];
        end
      end
    end
  endgenerate

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.enable    <= {EN_RESET, EN_RESET};
      st.gate      <= GATE_RESET;
      st.ratio_sel <= RATIO_RESET;
      st.rate_sel  <= RATE_RESET;
      st.pend      <= {VOL_RESET, VOL_RESET};
      st.act       <= {VOL_RESET, VOL_RESET};
    end else begin
      st <= next_st;
    end
  end

  // Channel datapaths, one per side.
  logic [1:0][SAMPLE_W-1:0] level;

  generate
    for (genvar c = 0; c < 2; c++) begin : g_chan
      channel_path u_path (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (st.enable[c]),
        .tick      (st.tick),
        .word      (st.word[c]),
        .gain_code (st.act[c]),
        .level_out (level[c])
      );
    end
  endgenerate

  // Outputs straight from flip-flops.
  assign prdata    = st.prdata;
  assign pready    = st.pready;
  assign pslverr   = st.pslverr;
  assign conv_tick = st.tick;
  assign left_out  = level[0];
  assign right_out = level[1];

  // Gap counter between ticks, read only by the rate check.
  logic [5:0] gap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 6'h00;
    end else if (st.tick || !st.gate) begin
      gap <= 6'h01;
    end else begin
      gap <= gap + 6'h01;
    end
  end

  // Configuration change flag, read only by the rate check.
  logic cfg_moved;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_moved <= 1'b1;
    end else if (wr && hit_clk) begin
      cfg_moved <= 1'b1;
    end else if (st.tick) begin
      cfg_moved <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_vol_write;
    psel && penable && pready && pwrite && (hit_l || hit_r);
  endsequence

  sequence s_commit_write;
    s_vol_write ##0 pwdata[COMMIT_BIT];
  endsequence

  sequence s_plain_write;
    s_vol_write ##0 !pwdata[COMMIT_BIT];
  endsequence

  sequence s_vol_read;
    psel && !penable && !pwrite;
  endsequence

  a_commit_both: assert property (s_commit_write |=> st.act == st.pend)
    else $error("commit did not load both gains");
  a_commit_either: assert property (s_commit_write ##1 1'b1 |-> ##1 $stable(st.act))
    else $error("active gains moved after commit");
  a_nocommit_holds: assert property (s_plain_write |=> $stable(st.act))
    else $error("plain volume write changed active gain");
  a_left_readback: assert property (s_vol_read ##0 hit_l |=> prdata == {24'h0, st.pend[0]})
    else $error("left code readback wrong");
  a_right_readback: assert property (s_vol_read ##0 hit_r |=> prdata == {24'h0, st.pend[1]})
    else $error("right code readback wrong");
  a_commit_reads_0: assert property (s_vol_read ##0 (hit_l || hit_r) |=> !prdata[COMMIT_BIT])
    else $error("commit bit read back as one");
  a_tick_gated: assert property (!st.gate ##1 !st.gate |-> !conv_tick)
    else $error("tick without clock gate");
  a_tick_period: assert property (conv_tick && !cfg_moved && $past(conv_tick) == 1'b0
                                  |-> gap == {1'b0, div})
    else $error("tick spacing does not match divider");
  a_enable_write: assert property (psel && penable && pready && pwrite && hit_pwr
                                   |=> st.enable == {$past(pwdata[RIGHT_EN_BIT]),
                                                     $past(pwdata[LEFT_EN_BIT])})
    else $error("enable bits not taken from write");
  a_left_off_zero: assert property (!st.enable[0] ##1 !st.enable[0] |-> left_out == '0)
    else $error("left output while disabled");
  a_right_off_zero: assert property (!st.enable[1] ##1 !st.enable[1] |-> right_out == '0)
    else $error("right output while disabled");
  a_unmapped_err: assert property (setup && !mapped |=> pready && pslverr)
    else $error("unmapped address not flagged");
endmodule

/* test/sample_source.sv */
// Behavioural digital audio interface that hands sample pairs to the block.
`timescale 1ns/1ps
module sample_source (
  input  wire logic        pclk,     // Core clock.
  input  wire logic        presetn,  // Asynchronous reset, active low.
  input  wire logic        run,      // Stream sample pairs while high.
  input  wire logic [23:0] word_l,   // Left word to send.
  input  wire logic [23:0] word_r,   // Right word to send.
  output logic             in_valid, // Pair strobe.
  output logic      [23:0] in_left,  // Left sample word.
  output logic      [23:0] in_right  // Right sample word.
);
  logic [1:0] phase;
  // One pair every fourth cycle; between pairs the words are inverted so stale data never looks valid.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase    <= 2'h0;
      in_valid <= 1'b0;
      in_left  <= 24'h0;
      in_right <= 24'h0;
    end else begin
      phase    <= phase + 2'h1;
      in_valid <= run && (phase == 2'h3);
      in_left  <= (run && phase == 2'h3) ? word_l : ~in_left;
      in_right <= (run && phase == 2'h3) ? word_r : ~in_right;
    end
  end
endmodule

/* test/dac_volume_top_tb.sv */
// Self-checking bench for the converter enables, rate tick and digital volume.
`timescale 1ns/1ps
module dac_volume_top_tb;
  import dac_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, in_valid;
  logic        beep_on, conv_tick, run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] in_left, in_right, beep_word, left_out, right_out, word_l, word_r;
  logic        err;
  int          failures, samples_checked, cycles;
  int          div_table [8] = '{2, 3, 4, 6, 8, 12, 16, 24};

  dac_volume_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
    .beep_on(beep_on), .beep_word(beep_word), .conv_tick(conv_tick), .left_out(left_out),
    .right_out(right_out));

  sample_source i_src (.pclk(pclk), .presetn(presetn), .run(run), .word_l(word_l),
    .word_r(word_r), .in_valid(in_valid), .in_left(in_left), .in_right(in_right));

  // Free-running core clock at 125 MHz.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Cuts a hang short.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // Compares within a tolerance below the expected value; tol 0 means exact.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got,
                       input int tol);
    samples_checked++;
    if (!((got === exp) || ((^got !== 1'bx) && got <= exp && got + tol >= exp))) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; waits for pready and takes the answer at that edge.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    check("access cycles", 32'h1, n, 0);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Reads a register and compares it.
  task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(what, exp, rd, 0);
  endtask

  // Measures the steady spacing of converter ticks.
  task automatic period(input string what, input int exp);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (conv_tick !== 1'b1 && n < 100);
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_tick !== 1'b1 && n < 100);
    check(what, exp, n, 0);
  endtask

  // Register values after reset.
  task automatic t_reset;
    rdchk("left volume", VOL_L_IDX, 32'h0000_00C0);
    rdchk("right volume", VOL_R_IDX, 32'h0000_00C0);
    rdchk("enables", PWR_IDX, 32'h0);
    rdchk("active codes", STAT_IDX, 32'h0000_C0C0);
  endtask

  // Pending codes, commit from either register, and the write-only commit bit.
  task automatic t_commit;
    apb(1'b1, VOL_L_IDX, 32'h0000_0055);
    rdchk("pending left", VOL_L_IDX, 32'h0000_0055);
    rdchk("held active", STAT_IDX, 32'h0000_C0C0);
    apb(1'b1, VOL_R_IDX, 32'h0000_01A0);
    rdchk("commit reads zero", VOL_R_IDX, 32'h00A0);
    rdchk("both loaded", STAT_IDX, 32'h0000_A055);
    apb(1'b1, VOL_L_IDX, 32'h0000_0130);
    rdchk("commit via left", STAT_IDX, 32'h0000_A030);
    apb(1'b1, 8'h3F, 32'h0000_0001);
    check("unmapped error", 32'h1, {31'h0, err}, 0);
  endtask

  // Tick stands still without the gate and follows ratio and frame rate.
  task automatic t_tick;
    int n;
    n = 0;
    repeat (60) begin
      @(posedge pclk);
      n += int'(conv_tick !== 1'b0);
    end
    check("ticks gated off", 32'h0, n, 0);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, CLK_IDX, {26'h0, 2'h0, k[2:0], 1'b1});
      period("tick spacing", div_table[k]);
    end
    apb(1'b1, CLK_IDX, {26'h0, 2'h1, 3'h7, 1'b1});
    period("tick spacing rate 1", 12);
    apb(1'b1, CLK_IDX, {26'h0, 2'h3, 3'h0, 1'b1});
    period("tick spacing floor", 1);
  endtask

  // Enables, smoothing filter and gain codes seen on the output levels.
  task automatic t_stream;
    apb(1'b1, CLK_IDX, 32'h0000_0001);
    apb(1'b1, VOL_R_IDX, 32'h0000_00C0);
    apb(1'b1, VOL_L_IDX, 32'h0000_01C0);
    apb(1'b1, PWR_IDX, 32'h0000_0100);
    word_l <= 24'h10_0000;
    word_r <= 24'h10_0000;
    run    <= 1'b1;
    repeat (400) @(posedge pclk);
    check("left unity", 32'h0010_0000, {8'h0, left_out}, 3);
    check("right disabled", 32'h0, {8'h0, right_out}, 0);
    apb(1'b1, VOL_L_IDX, 32'h0000_01D0);
    repeat (20) @(posedge pclk);
    check("left +6 dB", 32'h0020_0000, {8'h0, left_out}, 6);
    apb(1'b1, VOL_L_IDX, 32'h0000_01B0);
    repeat (20) @(posedge pclk);
    check("left -6 dB", 32'h0008_0000, {8'h0, left_out}, 2);
    apb(1'b1, VOL_L_IDX, 32'h0000_0100);
    repeat (20) @(posedge pclk);
    check("left mute", 32'h0, {8'h0, left_out}, 0);
    apb(1'b1, PWR_IDX, 32'h0000_0080);
    apb(1'b1, VOL_L_IDX, 32'h0000_01C0);
    repeat (400) @(posedge pclk);
    check("left disabled", 32'h0, {8'h0, left_out}, 0);
    check("right unity", 32'h0010_0000, {8'h0, right_out}, 3);
  endtask

  // Beep words feed enabled channels only.
  task automatic t_beep;
    beep_word <= 24'h08_0000;
    beep_on   <= 1'b1;
    repeat (400) @(posedge pclk);
    check("right beep", 32'h0008_0000, {8'h0, right_out}, 3);
    check("left beep off", 32'h0, {8'h0, left_out}, 0);
    beep_on   <= 1'b0;
  endtask

  // A reset in mid-run silences both outputs and restores the registers.
  task automatic t_midreset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("left in reset", 32'h0, {8'h0, left_out}, 0);
    check("right in reset", 32'h0, {8'h0, right_out}, 0);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    beep_on = 1'b0;
    beep_word = 24'h0;
    run = 1'b0;
    word_l = 24'h0;
    word_r = 24'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_commit();
    t_tick();
    t_stream();
    t_beep();
    t_midreset();
    complete_run();
  end
endmodule
